// ==== src/txs_flags.sv ====
// Purpose : transmit status flags of an ethernet mac, with apb access
// Assumes : transmitter sequencing strobes come from logic on clk
// Notes   : carrier and collision pins are synchronised here
// ==========================================================
`timescale 1ns/1ps
module txs_flags
  import txs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crs_pin,
  input  wire logic        col_pin,
  input  wire logic        tx_start,
  input  wire logic        tx_defer,
  input  wire logic        tx_preamble,
  input  wire logic        tx_sfd,
  input  wire logic        tx_last,
  input  wire logic        loopback,
  input  wire logic        status_ack,
  output logic             tx_backoff,
  output logic             tx_abort,
  output logic      [15:0] stat_word,
  output logic             stat_valid,
  output logic             irq
);
  // ==========================================================
  // state
  logic [15:0]       tcr_r, tcr_nxt;
  logic [IRQ_W-1:0]  ist_r, ist_nxt, imk_r;
  logic [CNT_W-1:0]  coll_cnt_r;
  logic [WIN_W-1:0]  win_cnt_r;
  logic              win_run_r, mon_r, att_r, end_q_r;
  logic              crs_s1_r, crs_s2_r, col_s1_r, col_s2_r, col_prev_r;
  logic [31:0]       prdata_r;
  logic              pready_r, pslverr_r;
  logic              tx_backoff_r, tx_abort_r, stat_valid_r, irq_r;
  logic [15:0]       stat_word_r;

  // ==========================================================
  // decode
  wire        acc_go   = psel & penable & pready_r;
  wire        wr_go    = acc_go & pwrite;
  wire        hit_tcr  = (paddr == TCR_ADDR);
  wire        hit_ist  = (paddr == IST_ADDR);
  wire        hit_imk  = (paddr == IMK_ADDR);
  wire        mapped   = hit_tcr | hit_ist | hit_imk;
  wire        origin   = tcr_r[B_ORIGIN];
  wire        col_hit  = att_r & col_s2_r & ~col_prev_r;
  wire        win_late = win_run_r & (win_cnt_r >= WIN_W'(LATE_CYC));
  wire        first_at = (coll_cnt_r == '0);
  wire        exc_hit  = col_hit & (coll_cnt_r == MAX_COLL - 5'h01);
  wire        win_go   = origin ? tx_preamble : tx_sfd;
  wire        tx_end   = tx_last | exc_hit;
  wire [31:0] rd_mux   = hit_tcr ? {16'h0000, tcr_r} :
                         hit_ist ? {28'h000_0000, ist_r} :
                         hit_imk ? {28'h000_0000, imk_r} : 32'h0000_0000;

  // ==========================================================
  // transmit_control next value; clears first so sets win, except carrier seen, which clears never-seen after the start and preamble sets
  always_comb begin
    tcr_nxt = tcr_r;
    if (tx_start) begin
      tcr_nxt[B_EXD]  = 1'b0;
      tcr_nxt[B_CARRIER_DROPPED] = 1'b0;
      tcr_nxt[B_EXC]  = 1'b0;
      tcr_nxt[B_BCM]  = 1'b0;
      tcr_nxt[B_CARRIER_NEVER_SEEN] = 1'b1;
    end
    if (status_ack) begin
      tcr_nxt[B_DEF] = 1'b0;
      tcr_nxt[B_OWC] = 1'b0;
    end
    if (col_hit && !first_at)
      tcr_nxt[B_DEF] = 1'b0;
    if (tx_defer && first_at && !att_r)
      tcr_nxt[B_DEF] = 1'b1;
    if (tx_preamble)
      tcr_nxt[B_CARRIER_NEVER_SEEN] = 1'b1;
    // carrier only watched between delimiter and last byte
    if (mon_r && crs_s2_r)
      tcr_nxt[B_CARRIER_NEVER_SEEN] = 1'b0;
    if (mon_r && !crs_s2_r)
      tcr_nxt[B_CARRIER_DROPPED] = 1'b1;
    if (col_hit && win_late)
      tcr_nxt[B_OWC] = 1'b1;
    if (exc_hit)
      tcr_nxt[B_EXC] = 1'b1;
    // loopback never sees its own carrier, report it as such
    if (tx_last && loopback) begin
      tcr_nxt[B_CARRIER_NEVER_SEEN] = 1'b1;
      tcr_nxt[B_CARRIER_DROPPED] = 1'b1;
    end
    if (wr_go && hit_tcr)
      tcr_nxt = (tcr_nxt & ~CFG_MASK) | (pwdata[15:0] & CFG_MASK);
  end

  // ==========================================================
  // interrupt status, write one to clear, events win
  always_comb begin
    ist_nxt = ist_r;
    if (wr_go && hit_ist)
      ist_nxt = ist_r & ~pwdata[IRQ_W-1:0];
    if (end_q_r) begin
      ist_nxt[I_DONE] = 1'b1;
      if (tcr_r[B_CARRIER_DROPPED])
        ist_nxt[I_CARRIER_DROPPED] = 1'b1;
    end
    if (exc_hit)
      ist_nxt[I_EXC] = 1'b1;
    if (col_hit && win_late)
      ist_nxt[I_OWC] = 1'b1;
  end

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      crs_s1_r   <= 1'b0;
      crs_s2_r   <= 1'b0;
      col_s1_r   <= 1'b0;
      col_s2_r   <= 1'b0;
      col_prev_r <= 1'b0;
    end else if (clk_en) begin
      crs_s1_r   <= crs_pin;
      crs_s2_r   <= crs_s1_r;
      col_s1_r   <= col_pin;
      col_s2_r   <= col_s1_r;
      col_prev_r <= col_s2_r;
    end
  end

  // ==========================================================
  // flags and registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tcr_r <= TCR_RST;
      ist_r <= '0;
      imk_r <= '0;
    end else if (clk_en) begin
      tcr_r <= tcr_nxt;
      ist_r <= ist_nxt;
      if (wr_go && hit_imk)
        imk_r <= pwdata[IRQ_W-1:0];
    end
  end

  // ==========================================================
  // attempt sequencing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      coll_cnt_r <= '0;
      att_r      <= 1'b0;
      mon_r      <= 1'b0;
      win_run_r  <= 1'b0;
      win_cnt_r  <= '0;
    end else if (clk_en) begin
      if (tx_start)
        coll_cnt_r <= '0;
      else if (col_hit)
        coll_cnt_r <= coll_cnt_r + 5'h01;
      if (col_hit || tx_last)
        att_r <= 1'b0;
      else if (tx_preamble)
        att_r <= 1'b1;
      if (col_hit || tx_last)
        mon_r <= 1'b0;
      else if (tx_sfd)
        mon_r <= 1'b1;
      if (col_hit || tx_last)
        win_run_r <= 1'b0;
      else if (win_go)
        win_run_r <= 1'b1;
      // saturate so a long frame never wraps back into the window
      if (win_go && !win_run_r)
        win_cnt_r <= '0;
      else if (win_run_r && !win_late)
        win_cnt_r <= win_cnt_r + 11'h001;
    end
  end

  // ==========================================================
  // outputs to the transmitter and descriptor writer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_backoff_r <= 1'b0;
      tx_abort_r   <= 1'b0;
      end_q_r      <= 1'b0;
      stat_valid_r <= 1'b0;
      stat_word_r  <= '0;
      irq_r        <= 1'b0;
    end else if (clk_en) begin
      tx_backoff_r <= col_hit & ~exc_hit;
      tx_abort_r   <= exc_hit;
      end_q_r      <= tx_end;
      stat_valid_r <= end_q_r;
      if (end_q_r)
        stat_word_r <= {coll_cnt_r, tcr_r[10:0]};
      irq_r <= |(ist_nxt & imk_r);
    end
  end

  // ==========================================================
  // apb slave, one wait state per access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else if (clk_en) begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      if (psel && penable && !pready_r)
        prdata_r <= rd_mux;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign tx_backoff = tx_backoff_r;
  assign tx_abort   = tx_abort_r;
  assign stat_word  = stat_word_r;
  assign stat_valid = stat_valid_r;
  assign irq        = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_def_set;
    clk_en && tx_defer && first_at && !att_r && !(wr_go && hit_tcr) |=> tcr_r[B_DEF];
  endproperty
  a_def_set: assert property (p_def_set) else $error("defer flag not set");

  property p_def_clr;
    clk_en && col_hit && !first_at && !tx_defer |=> !tcr_r[B_DEF];
  endproperty
  a_def_clr: assert property (p_def_clr) else $error("defer flag kept");

  property p_ack_clr;
    clk_en && status_ack && !tx_defer && !col_hit |=> !tcr_r[B_DEF] && !tcr_r[B_OWC];
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("ack left flags");

  property p_carrier_never_seen;
    clk_en && mon_r && crs_s2_r && !tx_preamble && !(tx_last && loopback)
      |=> !tcr_r[B_CARRIER_NEVER_SEEN];
  endproperty
  a_carrier_never_seen: assert property (p_carrier_never_seen) else $error("carrier seen, flag kept");

  property p_loop;
    clk_en && tx_last && loopback |=> tcr_r[B_CARRIER_NEVER_SEEN] && tcr_r[B_CARRIER_DROPPED];
  endproperty
  a_loop: assert property (p_loop) else $error("loopback carrier flags");

  property p_carrier_dropped;
    clk_en && mon_r && !crs_s2_r && !tx_start |=> tcr_r[B_CARRIER_DROPPED];
  endproperty
  a_carrier_dropped: assert property (p_carrier_dropped) else $error("carrier drop missed");

  property p_both;
    stat_valid_r && stat_word_r[B_CARRIER_NEVER_SEEN] |-> stat_word_r[B_CARRIER_DROPPED];
  endproperty
  a_both: assert property (p_both) else $error("carrier flags apart");

  property p_exc;
    clk_en && col_hit && coll_cnt_r == 5'h0F && !tx_start
      |=> tx_abort_r && tcr_r[B_EXC] && coll_cnt_r == MAX_COLL;
  endproperty
  a_exc: assert property (p_exc) else $error("no abort at 16");

  property p_abort_cause;
    tx_abort_r |-> $past(coll_cnt_r) == 5'h0F;
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("stray abort");

  property p_late;
    clk_en && col_hit && win_late && !exc_hit
      |=> tcr_r[B_OWC] && tx_backoff_r && !tx_abort_r;
  endproperty
  a_late: assert property (p_late) else $error("late collision handling");

  property p_status;
    clk_en && end_q_r |=> stat_valid_r && stat_word_r[15:11] == $past(coll_cnt_r);
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");

  property p_start;
    clk_en && tx_start && !tx_last && !col_hit
      |=> tcr_r[B_CARRIER_NEVER_SEEN] && !tcr_r[B_EXC] && !tcr_r[B_BCM] && !tcr_r[B_EXD]
          && coll_cnt_r == '0;
  endproperty
  a_start: assert property (p_start) else $error("start clear wrong");

  property p_rst;
    $fell(sys_rst) |-> tcr_r[B_CARRIER_NEVER_SEEN] && tcr_r[B_BCM];
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");

  property p_owc_clr;
    clk_en && status_ack && !col_hit |=> !tcr_r[B_OWC];
  endproperty
  a_owc_clr: assert property (p_owc_clr) else $error("late flag kept after ack");

  property p_owc_early;
    clk_en && col_hit && !win_late && !tcr_r[B_OWC] |=> !tcr_r[B_OWC];
  endproperty
  a_owc_early: assert property (p_owc_early) else $error("late flag too early");

  property p_win_start;
    clk_en && win_go && !win_run_r && !col_hit && !tx_last |=> win_run_r && win_cnt_r == '0;
  endproperty
  a_win_start: assert property (p_win_start) else $error("window origin wrong");

  property p_coll_inc;
    clk_en && col_hit && !tx_start |=> coll_cnt_r == $past(coll_cnt_r) + 5'h01;
  endproperty
  a_coll_inc: assert property (p_coll_inc) else $error("collision count wrong");
endmodule // txs_flags

// ==== src/txs_pkg.sv ====
// Purpose : constants for the transmit status flag block
// Assumes : 20 MHz clock, APB with 32-bit data
// Notes   : transmit_control sits at word index 3
package txs_pkg;
  // ==========================================================
  // register map
  localparam logic [5:0] TCR_IDX   = 6'h03;
  localparam logic [7:0] TCR_ADDR  = {TCR_IDX, 2'b00};
  localparam logic [7:0] IST_ADDR  = 8'h10;
  localparam logic [7:0] IMK_ADDR  = 8'h14;
  // ==========================================================
  // transmit_control fields
  localparam int         B_CFG_LO  = 12;
  localparam int         B_ORIGIN  = 14;
  localparam int         B_EXD     = 10;
  localparam int         B_DEF     = 9;
  localparam int         B_CARRIER_NEVER_SEEN    = 8;
  localparam int         B_CARRIER_DROPPED    = 7;
  localparam int         B_EXC     = 6;
  localparam int         B_OWC     = 5;
  localparam int         B_BCM     = 1;
  localparam logic [15:0] TCR_RST  = 16'h0102;
  localparam logic [15:0] CFG_MASK = 16'hF000;
  // ==========================================================
  // interrupt status bits
  localparam int         I_DONE    = 0;
  localparam int         I_EXC     = 1;
  localparam int         I_OWC     = 2;
  localparam int         I_CARRIER_DROPPED    = 3;
  localparam int         IRQ_W     = 4;
  // ==========================================================
  // timing
  localparam int         CLK_MHZ   = 20;
  localparam int         LATE_NS   = 51200;
  localparam int         LATE_CYC  = (LATE_NS * CLK_MHZ + 999) / 1000;
  localparam int         CNT_W     = 5;
  localparam int         WIN_W     = 11;
  localparam logic [CNT_W-1:0] MAX_COLL = 5'h10;
endpackage

// ==== tb/txs_medium.sv ====
// Purpose: carrier and collision model of the medium beside the transmitter
// Assumes: tx_on is high while the bench has an attempt on the wire
// Notes  : mode 0 carrier follows tx, 1 never seen, 2 short drop mid-frame
`timescale 1ns/1ps
module txs_medium (
  input  wire logic       clk,
  input  wire logic       tx_on,
  input  wire logic [1:0] mode,
  input  wire logic       col_req,
  output logic            crs_pin,
  output logic            col_pin
);
  int age  = 0;
  int colc = 0;
  // ==========================================================
  // medium timing
  always @(posedge clk) begin
    age  <= tx_on ? age + 1 : 0;
    colc <= col_req ? 3 : (colc > 0 ? colc - 1 : 0);
  end
  // quiet wire reads as no carrier; the drop sits well inside the watched span
  assign crs_pin = tx_on && mode != 2'd1 && !(mode == 2'd2 && age >= 20 && age < 26);
  assign col_pin = colc > 0;
endmodule // txs_medium

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for txs_flags
// Assumes: clk_en dropped once to check the freeze, medium model drives the pins
// Notes  : expected flags come from the small model inside pkt
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import txs_pkg::*;
  logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        lb = 0, ton = 0, colq = 0, pready, pslverr, crs, col, er;
  logic        tx_backoff, tx_abort, stat_valid, irq;
  logic        ce = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'h0000_75CF;
  logic [15:0] stat_word, sw, cfg = 16'h0000, tst = 16'h0102;
  logic [5:0]  stb = 6'h00;
  logic [1:0]  mode = 2'h0;
  int          err_count = 0, checks_done = 0, nb = 0, na = 0, nv = 0, org = 0, msk = 15;

  always #25 clk = ~clk;

  txs_flags dut (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crs_pin(crs), .col_pin(col), .tx_start(stb[0]),
    .tx_defer(stb[1]), .tx_preamble(stb[2]), .tx_sfd(stb[3]), .tx_last(stb[4]),
    .loopback(lb), .status_ack(stb[5]), .tx_backoff(tx_backoff), .tx_abort(tx_abort),
    .stat_word(stat_word), .stat_valid(stat_valid), .irq(irq));
  txs_medium med (.clk(clk), .tx_on(ton), .mode(mode), .col_req(colq), .crs_pin(crs),
    .col_pin(col));
  // ==========================================================
  // output monitors
  always @(posedge clk) begin
    if (tx_backoff === 1'b1) nb++;
    if (tx_abort === 1'b1) na++;
    if (stat_valid === 1'b1) begin
      sw = stat_word;
      nv++;
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int i);
    stb[i] <= 1'b1;
    @(posedge clk);
    stb[i] <= 1'b0;
  endtask
  // idle edge at the end so the next call never reassigns psel in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // request held until pready is seen high at a rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic setcfg(input int o);
    org = o;
    cfg = 16'(rnd() & 32'h0000_B000) | 16'(o << 14);
    apb(1'b1, TCR_ADDR, (rnd() & 32'hFFFF_0000) | {16'h0000, cfg} | 32'h0000_0FFF);
    apb(1'b0, TCR_ADDR, 32'h0000_0000);
    `CHK("tcr_cfg", {16'h0000, cfg | tst}, rd)
  endtask
  // ==========================================================
  // one packet: defer flag, carrier mode, collisions, sfd delay, gap, loopback
  task automatic pkt(input int dfr, cm, ncol, sd, gap, l);
    int nb0 = nb, na0 = na, nv0 = nv, a = 0, n = 0, ow = 0, c, ie;
    logic [15:0] st;
    mode <= cm[1:0];
    lb <= l[0];
    pulse(0);
    if (dfr != 0) pulse(1);
    do begin
      ton <= 1'b1;
      pulse(2);
      wcyc(sd);
      pulse(3);
      wcyc(gap);
      if (a < ncol) begin
        colq <= 1'b1;
        @(posedge clk);
        colq <= 1'b0;
        wcyc(6);
        // collision edge is seen four edges after the gap ends
        if (gap + 4 + (org != 0 ? sd + 1 : 0) >= LATE_CYC) ow = 1;
      end else pulse(4);
      ton <= 1'b0;
      a++;
      wcyc(4);
    end while (a <= ncol && a < 16);
    while (nv == nv0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (nv == nv0) err_count++;
    c = ncol > 15 ? 16 : ncol;
    // a collision on the first attempt alone keeps the deferral flag
    st = 16'((dfr != 0 && ncol < 2) << 9 | (cm == 1 || l != 0) << 8 |
      (cm != 0 || l != 0) << 7 | (ncol > 15) << 6 | ow << 5);
    `CHK("stat_word", {c[4:0], st[10:0]}, sw)
    `CHK("backoffs", ncol > 15 ? 15 : ncol, nb - nb0)
    `CHK("aborts", ncol > 15 ? 1 : 0, na - na0)
    ie = 1 | (ncol > 15) << 1 | ow << 2 | (cm != 0 || l != 0) << 3;
    pulse(5);
    wcyc(2);
    `CHK("irq", |(ie & msk), irq)
    tst = st & 16'hFDDF;
    apb(1'b0, TCR_ADDR, 32'h0000_0000);
    `CHK("tcr_after_ack", {16'h0000, cfg | tst}, rd)
    apb(1'b0, IST_ADDR, 32'h0000_0000);
    `CHK("int_status", ie, rd)
    apb(1'b1, IST_ADDR, ie);
    apb(1'b0, IST_ADDR, 32'h0000_0000);
    `CHK("int_clear", 32'h0000_0000, rd)
    `CHK("irq_clear", 1'b0, irq)
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, TCR_ADDR, 32'h0000_0000);
    `CHK("tcr_reset", 32'h0000_0102, rd)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_data", 32'h0000_0000, rd)
    apb(1'b1, IMK_ADDR, 32'h0000_000F);
    setcfg(0);
    pkt(1, 0, 0, 8, 40, 0);
    pkt(0, 1, 0, 8, 40, 0);
    // a start strobe while frozen must leave the carrier flags alone
    ce <= 1'b0;
    pulse(0);
    ce <= 1'b1;
    apb(1'b0, TCR_ADDR, 32'h0000_0000);
    `CHK("tcr_frozen", {16'h0000, cfg | tst}, rd)
    pkt(0, 2, 0, 8, 48, 0);
    pkt(0, 0, 0, 8, 40, 1);
    pkt(1, 0, 1, 8, 40, 0);
    pkt(1, 0, 2, 8, 40 + rnd() % 32, 0);
    pkt(0, 0, 16, 8, 40, 0);
    apb(1'b1, IMK_ADDR, 32'h0000_0000);
    msk = 0;
    pkt(0, 0, 1, 8, 1100, 0);
    apb(1'b1, IMK_ADDR, 32'h0000_000F);
    msk = 15;
    // same timing, late only when the window opens at the preamble
    for (int o = 0; o < 2; o++) begin
      setcfg(o);
      pkt(0, 0, 1, 600, 600, 0);
    end
    // mid-run reset drops the configured bits and the mask
    sys_rst <= 1'b1;
    wcyc(2);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, TCR_ADDR, 32'h0000_0000);
    `CHK("tcr_rerst", 32'h0000_0102, rd)
    apb(1'b0, IMK_ADDR, 32'h0000_0000);
    `CHK("imk_rerst", 32'h0000_0000, rd)
    complete_run;
  end
  // a hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run;
  end
endmodule // tb_top
